// ### shared/uptc_pkg.sv
package uptc_pkg;
  // Configuration offsets (byte addresses, dword aligned)
  localparam logic [7:0] PORT3_TRIM_OFS = 8'hA8;
  localparam logic [7:0] PORT4_TRIM_OFS = 8'hAC;
  localparam logic [7:0] CAP_HDR_OFS = 8'hE0;
  // Offset of the preceding capability whose next pointer leads here
  localparam logic [7:0] PREV_CAP_OFS = 8'h8C;

  // Trim register layout
  localparam int TRIM_PULLUP_LSB = 0;
  localparam int TRIM_PULLDN_LSB = 1;
  localparam int TRIM_AMPL_LSB = 3;
  localparam int TRIM_SLOPE_LSB = 5;
  localparam int TRIM_DISC_LSB = 9;
  localparam int TRIM_SQL_LSB = 11;
  localparam int TRIM_CAL_LSB = 13;
  localparam int TRIM_CP_LSB = 16;
  localparam int TRIM_FSEDGE_LSB = 18;
  localparam int TRIM_LSEDGE_LSB = 20;
  localparam int TRIM_PREEMP_LSB = 22;
  localparam logic [31:0] TRIM_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] TRIM_RESET = 32'h0014_9400;

  // Capability header layout
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_NEXT_LSB = 8;
  localparam int CAP_VER_LSB = 16;
  localparam int CAP_TYPE_LSB = 20;
  localparam int CAP_SLOT_BIT = 24;
  localparam int CAP_MSGNUM_LSB = 25;
  localparam logic [31:0] CAP_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] CAP_RESET = 32'h0011_0010;

  // Next pointer of the preceding capability, bits 15:8 of its dword
  localparam int PREV_NEXT_LSB = 8;
  localparam logic [7:0] PREV_NEXT_RESET = 8'hE0;
endpackage

// ### core/uptc_trim_cap_regs.sv
`timescale 1ns/1ps
module uptc_trim_cap_regs
  import uptc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host configuration access
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [31:0] cfgWrData,
  output logic cfgAck,
  output logic [31:0] cfgRdData,
  // Side-band default load (management bus or EEPROM autoload)
  input wire logic loadValid,
  input wire logic [7:0] loadAddr,
  input wire logic [31:0] loadData,
  // Trim words to the analog ports
  output logic [23:0] port3Trim,
  output logic [23:0] port4Trim,
  // Next pointer of the preceding capability
  output logic [7:0] prevCapNextPtr
);

  logic [31:0] trim3_q;
  logic [31:0] trim4_q;
  logic [31:0] cap_q;
  logic [7:0] prevNext_q;
  logic cfgAck_q;
  logic [31:0] rdData_q;
  logic trim3Loaded_q;
  logic trim4Loaded_q;
  logic capLoaded_q;
  logic prevLoaded_q;

  // Read decode; an unmapped offset reads zero so a host probing the space sees no error
  function automatic logic [31:0] read_word(
    input logic [7:0] addr,
    input logic [31:0] t3,
    input logic [31:0] t4,
    input logic [31:0] cp
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      PORT3_TRIM_OFS: v = t3 & TRIM_MASK;
      PORT4_TRIM_OFS: v = t4 & TRIM_MASK;
      CAP_HDR_OFS: v = cp & CAP_MASK;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Defaults come from reset; only the side-band path may replace them.
  // Host writes are deliberately not routed here at all.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim3_q <= TRIM_RESET;
      trim4_q <= TRIM_RESET;
      cap_q <= CAP_RESET;
      prevNext_q <= PREV_NEXT_RESET;
    end else if (loadValid) begin
      if (loadAddr == PORT3_TRIM_OFS) begin
        trim3_q <= loadData & TRIM_MASK;
      end
      if (loadAddr == PORT4_TRIM_OFS) begin
        trim4_q <= loadData & TRIM_MASK;
      end
      if (loadAddr == CAP_HDR_OFS) begin
        cap_q <= loadData & CAP_MASK;
      end
      if (loadAddr == PREV_CAP_OFS) begin
        prevNext_q <= loadData[PREV_NEXT_LSB +: 8];
      end
    end
  end

  // Tracks whether each word still holds its reset default
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim3Loaded_q <= 1'b0;
      trim4Loaded_q <= 1'b0;
      capLoaded_q <= 1'b0;
      prevLoaded_q <= 1'b0;
    end else if (loadValid) begin
      if (loadAddr == PORT3_TRIM_OFS) begin
        trim3Loaded_q <= 1'b1;
      end
      if (loadAddr == PORT4_TRIM_OFS) begin
        trim4Loaded_q <= 1'b1;
      end
      if (loadAddr == CAP_HDR_OFS) begin
        capLoaded_q <= 1'b1;
      end
      if (loadAddr == PREV_CAP_OFS) begin
        prevLoaded_q <= 1'b1;
      end
    end
  end

  // Every access is answered one cycle later; writes are acked and dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgAck_q <= 1'b0;
      rdData_q <= 32'h0000_0000;
    end else begin
      cfgAck_q <= cfgReq;
      if (cfgReq && !cfgWrite) begin
        rdData_q <= read_word(cfgAddr, trim3_q, trim4_q, cap_q);
      end else if (cfgReq) begin
        rdData_q <= 32'h0000_0000;
      end
    end
  end

  assign cfgAck = cfgAck_q;
  assign cfgRdData = rdData_q;
  assign port3Trim = trim3_q[23:0];
  assign port4Trim = trim4_q[23:0];
  assign prevCapNextPtr = prevNext_q;

  AST_TRIM_ZERO_FIELDS: assert property (@(posedge clk) disable iff (rst)
    !trim3Loaded_q |-> (trim3_q[TRIM_PULLUP_LSB] == 1'b0 && trim3_q[TRIM_PULLDN_LSB +: 2] == 2'h0
      && trim3_q[TRIM_AMPL_LSB +: 2] == 2'h0 && trim3_q[TRIM_SLOPE_LSB +: 4] == 4'h0
      && trim3_q[TRIM_CP_LSB +: 2] == 2'h0 && trim3_q[TRIM_PREEMP_LSB +: 2] == 2'h0))
    else $error("Port 3 trim zero fields wrong before load");

  AST_TRIM_THRESHOLDS: assert property (@(posedge clk) disable iff (rst)
    !trim4Loaded_q |-> (port4Trim[TRIM_DISC_LSB +: 2] == 2'h2
      && port4Trim[TRIM_SQL_LSB +: 2] == 2'h2))
    else $error("Port 4 threshold defaults wrong");

  AST_TRIM_CAL_REF: assert property (@(posedge clk) disable iff (rst)
    (cfgReq && !cfgWrite && cfgAddr == PORT3_TRIM_OFS && !trim3Loaded_q)
      |=> cfgRdData[TRIM_CAL_LSB +: 3] == 3'h4)
    else $error("Calibration reference default not read back");

  AST_TRIM_EDGE_RATE: assert property (@(posedge clk) disable iff (rst)
    !trim3Loaded_q |-> (port3Trim[TRIM_FSEDGE_LSB +: 2] == 2'h1
      && port3Trim[TRIM_LSEDGE_LSB +: 2] == 2'h1))
    else $error("Edge-rate defaults wrong");

  AST_HOST_WRITE_NO_EFFECT: assert property (@(posedge clk) disable iff (rst)
    (cfgReq && cfgWrite && !loadValid)
      |=> ($stable(trim3_q) && $stable(trim4_q) && $stable(cap_q) && $stable(prevNext_q)))
    else $error("Host write altered a field");

  AST_PORT4_READ: assert property (@(posedge clk) disable iff (rst)
    (cfgReq && !cfgWrite && cfgAddr == PORT4_TRIM_OFS)
      |=> (cfgAck && cfgRdData == {8'h00, $past(trim4_q[23:0])}))
    else $error("Port 4 trim read mismatch");

  AST_CAP_ID: assert property (@(posedge clk) disable iff (rst)
    (cfgReq && !cfgWrite && cfgAddr == CAP_HDR_OFS && !capLoaded_q)
      |=> cfgRdData[CAP_ID_LSB +: 8] == 8'h10)
    else $error("Capability ID not 10h");

  AST_CAP_NEXT_END: assert property (@(posedge clk) disable iff (rst)
    !capLoaded_q |-> cap_q[CAP_NEXT_LSB +: 8] == 8'h00)
    else $error("Next pointer not 00h");

  AST_CAP_VERSION: assert property (@(posedge clk) disable iff (rst)
    !capLoaded_q |-> cap_q[CAP_VER_LSB +: 4] == 4'h1)
    else $error("Capability version not 1");

  AST_CAP_PORT_TYPE: assert property (@(posedge clk) disable iff (rst)
    (cfgReq && !cfgWrite && cfgAddr == CAP_HDR_OFS && !capLoaded_q)
      |=> cfgRdData[CAP_TYPE_LSB +: 4] == 4'h1)
    else $error("Port type not 1h");

  AST_CAP_SLOT_ZERO: assert property (@(posedge clk) disable iff (rst)
    cfgAck |-> cfgRdData[CAP_SLOT_BIT] == 1'b0)
    else $error("Slot implemented bit set");

  AST_CAP_MSGNUM_ZERO: assert property (@(posedge clk) disable iff (rst)
    cfgAck |-> cfgRdData[CAP_MSGNUM_LSB +: 5] == 5'h00)
    else $error("Interrupt message number nonzero");

  AST_PREV_NEXT_PTR: assert property (@(posedge clk) disable iff (rst)
    !prevLoaded_q |-> prevCapNextPtr == 8'hE0)
    else $error("Preceding next pointer not E0h");

  AST_TRIM4_ZERO_FIELDS: assert property (@(posedge clk) disable iff (rst)
    !trim4Loaded_q |-> (trim4_q[TRIM_PULLUP_LSB] == 1'b0 && trim4_q[TRIM_PULLDN_LSB +: 2] == 2'h0
      && trim4_q[TRIM_AMPL_LSB +: 2] == 2'h0 && trim4_q[TRIM_SLOPE_LSB +: 4] == 4'h0
      && trim4_q[TRIM_CP_LSB +: 2] == 2'h0 && trim4_q[TRIM_PREEMP_LSB +: 2] == 2'h0))
    else $error("Port 4 trim zero fields wrong before load");

  AST_TRIM3_THRESHOLDS: assert property (@(posedge clk) disable iff (rst)
    !trim3Loaded_q |-> (port3Trim[TRIM_DISC_LSB +: 2] == 2'h2
      && port3Trim[TRIM_SQL_LSB +: 2] == 2'h2))
    else $error("Port 3 threshold defaults wrong");

  AST_TRIM4_CAL_REF: assert property (@(posedge clk) disable iff (rst)
    !trim4Loaded_q |-> port4Trim[TRIM_CAL_LSB +: 3] == 3'h4)
    else $error("Port 4 calibration reference default wrong");

  AST_TRIM4_EDGE_RATE: assert property (@(posedge clk) disable iff (rst)
    !trim4Loaded_q |-> (port4Trim[TRIM_FSEDGE_LSB +: 2] == 2'h1
      && port4Trim[TRIM_LSEDGE_LSB +: 2] == 2'h1))
    else $error("Port 4 edge-rate defaults wrong");

  AST_PORT3_READ: assert property (@(posedge clk) disable iff (rst)
    (cfgReq && !cfgWrite && cfgAddr == PORT3_TRIM_OFS)
      |=> (cfgAck && cfgRdData == {8'h00, $past(trim3_q[23:0])}))
    else $error("Port 3 trim read mismatch");

  AST_ACK_AND_RESERVED: assert property (@(posedge clk) disable iff (rst)
    cfgReq |=> (cfgAck && cfgRdData[31:30] == 2'h0
      && (!$past(cfgWrite) || cfgRdData == 32'h0000_0000)))
    else $error("Access not acked or reserved bits set");

endmodule

// ### testbench/uptc_host_model.sv
`timescale 1ns/1ps
module uptc_host_model (
  // Clock
  input wire logic clk,
  // Configuration requests toward the bank
  output logic cfgReq,
  output logic cfgWrite,
  output logic [7:0] cfgAddr,
  output logic [31:0] cfgWrData,
  // Answers from the bank
  input wire logic cfgAck,
  input wire logic [31:0] cfgRdData
);
  initial begin
    cfgReq = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 8'h00;
    cfgWrData = 32'h0000_0000;
  end
  // One access; ok stays low if no answer comes within the bound
  task automatic access(input logic wr, input logic [7:0] a,
                        output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d = 32'h0000_0000;
    @(posedge clk);
    cfgReq <= 1'b1;
    cfgWrite <= wr;
    cfgAddr <= a;
    cfgWrData <= 32'hFFFF_FFFF;
    @(posedge clk);
    // Released request, address and data lines do not keep the old value; cfgWrite is left as it was
    cfgReq <= 1'b0;
    cfgAddr <= ~a;
    cfgWrData <= 32'h5A5A_5A5A;
    for (int n = 0; n < 3 && !ok; n++) begin
      #1;
      if (cfgAck === 1'b1) begin
        ok = 1'b1;
        d = cfgRdData;
      end else begin
        @(posedge clk);
      end
    end
  endtask
endmodule

// ### testbench/usb_phy_trim_and_pcie_cap_header_bench.sv
`timescale 1ns/1ps
module usb_phy_trim_and_pcie_cap_header_bench
  import uptc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfgReq, cfgWrite, cfgAck;
  logic [7:0] cfgAddr;
  logic [31:0] cfgWrData, cfgRdData;
  logic loadValid = 1'b0;
  logic [7:0] loadAddr = 8'h00;
  logic [31:0] loadData = 32'h0000_0000;
  logic [23:0] port3Trim, port4Trim;
  logic [7:0] prevCapNextPtr;
  int fail_count = 0;
  int checked = 0;
  // Field by field, high bits first
  localparam logic [31:0] TRIM_EXP = {8'h00, 2'b00, 2'b01, 2'b01, 2'b00, 3'b100, 2'b10,
                                      2'b10, 4'h0, 2'b00, 2'b00, 1'b0};
  localparam logic [31:0] CAP_EXP = {2'b00, 5'h00, 1'b0, 4'h1, 4'h1, 8'h00, 8'h10};
  always #2 clk = ~clk;
  uptc_host_model host (.clk(clk), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData), .cfgAck(cfgAck), .cfgRdData(cfgRdData));
  uptc_trim_cap_regs dut (.clk(clk), .rst(rst), .cfgReq(cfgReq), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgAck(cfgAck), .cfgRdData(cfgRdData),
    .loadValid(loadValid), .loadAddr(loadAddr), .loadData(loadData), .port3Trim(port3Trim),
    .port4Trim(port4Trim), .prevCapNextPtr(prevCapNextPtr));
  task automatic summarize;
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    host.access(wr, a, d, ok);
    chk("cfgAck", 32'h0000_0001, {31'h0, ok});
    // A missing answer ends the run
    if (ok !== 1'b1) summarize();
    chk("cfgRdData", exp, d);
  endtask
  task automatic load(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    loadValid <= 1'b1;
    loadAddr <= a;
    loadData <= d;
    @(posedge clk);
    loadValid <= 1'b0;
    loadAddr <= ~a;
    loadData <= ~d;
    #1;
  endtask
  task automatic defaults;
    acc(1'b0, 8'hA8, TRIM_EXP);
    acc(1'b0, 8'hAC, TRIM_EXP);
    acc(1'b0, 8'hE0, CAP_EXP);
    chk("port3Trim", TRIM_EXP, {8'h00, port3Trim});
    chk("port4Trim", TRIM_EXP, {8'h00, port4Trim});
    chk("prevCapNextPtr", 32'h0000_00E0, {24'h0, prevCapNextPtr});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    defaults();
    // Host writes of all ones must leave the whole bank untouched
    acc(1'b1, 8'hA8, 32'h0000_0000);
    acc(1'b1, 8'hAC, 32'h0000_0000);
    acc(1'b1, 8'hE0, 32'h0000_0000);
    acc(1'b1, 8'h8C, 32'h0000_0000);
    defaults();
    acc(1'b0, 8'h90, 32'h0000_0000);
    // Side-band loads replace defaults; hardwired bits stay zero
    load(8'hA8, 32'hFFFF_FFFF);
    chk("port3Trim", 32'h00FF_FFFF, {8'h00, port3Trim});
    acc(1'b0, 8'hA8, 32'h00FF_FFFF);
    load(8'hAC, 32'hA5A5_A5A5);
    chk("port4Trim", 32'h00A5_A5A5, {8'h00, port4Trim});
    acc(1'b0, 8'hAC, 32'h00A5_A5A5);
    load(8'hE0, 32'hFFFF_FFFF);
    acc(1'b0, 8'hE0, 32'h00FF_FFFF);
    load(8'h8C, 32'h0000_4400);
    chk("prevCapNextPtr", 32'h0000_0044, {24'h0, prevCapNextPtr});
    // A second reset in mid-run restores every default
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    defaults();
    summarize();
  end
endmodule
